// file: src/rtcis_top.v
// Interrupt sources of the RTC: periodic, alarm, power-fail; plus a battery flag that raises no interrupt.
// Assumes an Avalon-MM master, clock values and update strobe from the RTC
// core, and supply monitors that are already synchronous to clk.
`timescale 1ns/1ps
`include "rtcis_consts.vh"

module rtcis_top #(
    parameter WPT_CYCLES  = (`RTCIS_WPT_NS + `RTCIS_CLK_PERIOD_NS - 1)
                            / `RTCIS_CLK_PERIOD_NS,
    parameter HOLD_CYCLES = (`RTCIS_ADDR_HOLD_NS + `RTCIS_CLK_PERIOD_NS - 1)
                            / `RTCIS_CLK_PERIOD_NS
) (
    input  wire        clk,
    input  wire        resetn,
    input  wire        ce,
    input  wire [5:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    input  wire [3:0]  byteenable,
    output reg  [31:0] readdata,
    output reg         waitrequest,
    input  wire        tick_32k,
    input  wire        update_strobe,
    input  wire [7:0]  cur_seconds,
    input  wire [7:0]  cur_minutes,
    input  wire [7:0]  cur_hours,
    input  wire [7:0]  cur_date,
    input  wire        power_fail_detect,
    input  wire        backup_mode,
    input  wire        battery_ok,
    output reg         irq_n_out,
    output reg         irq_n_oe_n,
    output reg         supervisor_reset_req
);

    // ---------------------------------------------
    // Functions
    // ---------------------------------------------
    function byte_match;
        input [7:0] alarm;
        input [7:0] now;
        begin
            byte_match = (alarm[`RTCIS_ALM_MASK_HI] & alarm[`RTCIS_ALM_MASK_LO])
                       | (alarm == now);
        end
    endfunction

    function [7:0] merge_byte;
        input [7:0] old;
        input [7:0] wdata;
        input       lane;
        begin
            merge_byte = lane ? wdata : old;
        end
    endfunction

    // ---------------------------------------------
    // State
    // ---------------------------------------------
    localparam [15:0] WPT_LIMIT  = WPT_CYCLES[15:0];
    localparam [3:0]  HOLD_LIMIT = HOLD_CYCLES[3:0];

    reg [7:0]  alarm_seconds;
    reg [7:0]  alarm_minutes;
    reg [7:0]  alarm_hours;
    reg [7:0]  alarm_date;
    reg [3:0]  periodic_rate_sel;
    reg        periodic_irq_enable;
    reg        alarm_irq_enable;
    reg        alarm_in_backup_enable;
    reg        power_fail_irq_enable;
    reg        periodic_event_flag;
    reg        alarm_match_flag;
    reg        power_fail_flag;
    reg        battery_valid_flag;
    reg        battery_caught;
    reg        pfd_last;
    reg [15:0] wpt_count;
    reg        wpt_running;
    reg [3:0]  hold_count;
    reg [5:0]  hold_addr;
    reg        req_last;

    wire       period_done;
    wire [3:0] idx = address[5:2];
    wire       req = read | write;
    wire       accept = req & ~waitrequest;
    wire       flags_clear = accept & read & (idx == `RTCIS_IDX_FLAGS);
    wire       pfd_rise = power_fail_detect & ~pfd_last;

    reg [3:0]  next_hold_need;
    reg [31:0] next_readdata;
    reg        alarm_hit;
    reg        next_irq_active;

    // ---------------------------------------------
    // Periodic source
    // ---------------------------------------------
    rtcis_periodic #(
        .CNT_W (`RTCIS_PER_CNT_W)
    ) u_periodic (
        .clk         (clk),
        .resetn      (resetn),
        .ce          (ce),
        .tick_32k    (tick_32k),
        .rate_sel    (periodic_rate_sel),
        .period_done (period_done)
    );

    // ---------------------------------------------
    // Alarm compare
    // ---------------------------------------------
    always @* begin
        alarm_hit = update_strobe
                  & byte_match(alarm_seconds, cur_seconds)
                  & byte_match(alarm_minutes, cur_minutes)
                  & byte_match(alarm_hours, cur_hours)
                  & byte_match(alarm_date, cur_date);
    end

    // ---------------------------------------------
    // Interrupt output decision
    // ---------------------------------------------
    always @* begin
        if (backup_mode) begin
            next_irq_active = alarm_in_backup_enable & alarm_irq_enable
                            & alarm_match_flag;
        end else begin
            next_irq_active = (periodic_event_flag & periodic_irq_enable)
                            | (alarm_match_flag & alarm_irq_enable)
                            | (power_fail_flag & power_fail_irq_enable);
        end
    end

    // ---------------------------------------------
    // Read data mux by register index
    // ---------------------------------------------
    always @* begin
        next_readdata = 32'h0000_0000;
        case (idx)
            `RTCIS_IDX_ALM_SEC: next_readdata[7:0] = alarm_seconds;
            `RTCIS_IDX_ALM_MIN: next_readdata[7:0] = alarm_minutes;
            `RTCIS_IDX_ALM_HOUR: next_readdata[7:0] = alarm_hours;
            `RTCIS_IDX_ALM_DATE: next_readdata[7:0] = alarm_date;
            `RTCIS_IDX_INTR: begin
                next_readdata[`RTCIS_INTR_RATE_MSB:`RTCIS_INTR_RATE_LSB] = periodic_rate_sel;
                next_readdata[`RTCIS_INTR_POWER_FAIL_IRQ_ENABLE] = power_fail_irq_enable;
                next_readdata[`RTCIS_INTR_ABE]   = alarm_in_backup_enable;
                next_readdata[`RTCIS_INTR_PIE]   = periodic_irq_enable;
                next_readdata[`RTCIS_INTR_AIE]   = alarm_irq_enable;
            end
            `RTCIS_IDX_FLAGS: begin
                next_readdata[`RTCIS_FLG_BVF]  = battery_valid_flag;
                next_readdata[`RTCIS_FLG_POWER_FAIL_FLAG] = power_fail_flag;
                next_readdata[`RTCIS_FLG_PF]   = periodic_event_flag;
                next_readdata[`RTCIS_FLG_AF]   = alarm_match_flag;
            end
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    // ---------------------------------------------
    // Address hold need
    // ---------------------------------------------
    always @* begin
        // A destructive flags read waits for a stable address
        if (read && idx == `RTCIS_IDX_FLAGS) begin
            next_hold_need = HOLD_LIMIT;
        end else begin
            next_hold_need = 4'h1;
        end
    end

    // ---------------------------------------------
    // Request tracking
    // ---------------------------------------------
    // Only an address that moves under an open request restarts the
    // hold count, so a fresh request on a new address costs no cycle
    always @(posedge clk) begin
        if (!resetn) begin
            req_last  <= 1'b0;
            hold_addr <= 6'h00;
        end else if (ce) begin
            req_last  <= req & ~accept;
            hold_addr <= address;
        end
    end

    // ---------------------------------------------
    // Avalon slave handshake
    // ---------------------------------------------
    always @(posedge clk) begin
        if (!resetn) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
            hold_count  <= 4'h0;
        end else if (ce) begin
            if (!req || accept || (req_last && address != hold_addr)) begin
                hold_count  <= 4'h0;
                waitrequest <= 1'b1;
            end else if (hold_count + 4'h1 >= next_hold_need) begin
                waitrequest <= 1'b0;
                readdata    <= next_readdata;
            end else begin
                hold_count <= hold_count + 4'h1;
            end
        end
    end

    // ---------------------------------------------
    // Register writes
    // ---------------------------------------------
    always @(posedge clk) begin
        if (!resetn) begin
            alarm_seconds          <= `RTCIS_ALM_RESET;
            alarm_minutes          <= `RTCIS_ALM_RESET;
            alarm_hours            <= `RTCIS_ALM_RESET;
            alarm_date             <= `RTCIS_ALM_RESET;
            periodic_rate_sel      <= 4'h0;
            power_fail_irq_enable  <= 1'b0;
            alarm_in_backup_enable <= 1'b0;
            periodic_irq_enable    <= 1'b0;
            alarm_irq_enable       <= 1'b0;
        end else if (ce && accept && write) begin
            case (idx)
                `RTCIS_IDX_ALM_SEC:
                    alarm_seconds <= merge_byte(alarm_seconds, writedata[7:0], byteenable[0]);
                `RTCIS_IDX_ALM_MIN:
                    alarm_minutes <= merge_byte(alarm_minutes, writedata[7:0], byteenable[0]);
                `RTCIS_IDX_ALM_HOUR:
                    alarm_hours <= merge_byte(alarm_hours, writedata[7:0], byteenable[0]);
                `RTCIS_IDX_ALM_DATE:
                    alarm_date <= merge_byte(alarm_date, writedata[7:0], byteenable[0]);
                `RTCIS_IDX_INTR: begin
                    if (byteenable[0]) begin
                        periodic_rate_sel <=
                            writedata[`RTCIS_INTR_RATE_MSB:`RTCIS_INTR_RATE_LSB];
                        power_fail_irq_enable  <= writedata[`RTCIS_INTR_POWER_FAIL_IRQ_ENABLE];
                        alarm_in_backup_enable <= writedata[`RTCIS_INTR_ABE];
                        periodic_irq_enable    <= writedata[`RTCIS_INTR_PIE];
                        alarm_irq_enable       <= writedata[`RTCIS_INTR_AIE];
                    end
                end
                default: begin
                    // Flags are read-only; unmapped writes are dropped
                end
            endcase
        end
    end

    // ---------------------------------------------
    // Event flags: a set in the clearing cycle wins
    // ---------------------------------------------
    always @(posedge clk) begin
        if (!resetn) begin
            periodic_event_flag <= 1'b0;
            alarm_match_flag    <= 1'b0;
            power_fail_flag     <= 1'b0;
        end else if (ce) begin
            if (period_done) begin
                periodic_event_flag <= 1'b1;
            end else if (flags_clear) begin
                periodic_event_flag <= 1'b0;
            end
            if (alarm_hit) begin
                alarm_match_flag <= 1'b1;
            end else if (flags_clear) begin
                alarm_match_flag <= 1'b0;
            end
            if (pfd_rise) begin
                power_fail_flag <= 1'b1;
            end else if (flags_clear) begin
                power_fail_flag <= 1'b0;
            end
        end
    end

    // ---------------------------------------------
    // Power-fail detect edge
    // ---------------------------------------------
    // Flag and reset timer react to the edge only, so a long outage
    // that a read has already serviced does not raise the flag again
    always @(posedge clk) begin
        if (!resetn) begin
            pfd_last <= 1'b0;
        end else if (ce) begin
            pfd_last <= power_fail_detect;
        end
    end

    // ---------------------------------------------
    // Battery check caught once after reset release
    // ---------------------------------------------
    always @(posedge clk) begin
        if (!resetn) begin
            battery_caught     <= 1'b0;
            battery_valid_flag <= 1'b0;
        end else if (ce && !battery_caught) begin
            battery_caught     <= 1'b1;
            battery_valid_flag <= battery_ok;
        end
    end

    // ---------------------------------------------
    // Reset request trails the power-fail warning
    // ---------------------------------------------
    always @(posedge clk) begin
        if (!resetn) begin
            wpt_count            <= 16'h0000;
            wpt_running          <= 1'b0;
            supervisor_reset_req <= 1'b0;
        end else if (ce) begin
            if (!power_fail_detect) begin
                wpt_count            <= 16'h0000;
                wpt_running          <= 1'b0;
                supervisor_reset_req <= 1'b0;
            end else if (pfd_rise) begin
                wpt_count   <= 16'h0000;
                wpt_running <= 1'b1;
            end else if (wpt_running) begin
                if (wpt_count + 16'h0001 >= WPT_LIMIT) begin
                    wpt_running          <= 1'b0;
                    supervisor_reset_req <= 1'b1;
                end else begin
                    wpt_count <= wpt_count + 16'h0001;
                end
            end
        end
    end

    // ---------------------------------------------
    // Open-drain interrupt pin, enable low drives
    // ---------------------------------------------
    always @(posedge clk) begin
        if (!resetn) begin
            irq_n_out  <= 1'b0;
            irq_n_oe_n <= 1'b1;
        end else if (ce) begin
            irq_n_out  <= 1'b0;
            irq_n_oe_n <= ~next_irq_active;
        end
    end

endmodule // rtcis_top

// file: src/rtcis_consts.vh
// Constants for the RTC interrupt-source block: offsets, fields, timing.
// Assumes a 100 MHz clock and a 32.768 kHz timebase tick from the RTC core.
`ifndef RTCIS_CONSTS_VH
`define RTCIS_CONSTS_VH

// ---------------------------------------------
// Register indexes (byte address = 4 * index)
// ---------------------------------------------
`define RTCIS_IDX_ALM_SEC   4'h1
`define RTCIS_IDX_ALM_MIN   4'h3
`define RTCIS_IDX_ALM_HOUR  4'h5
`define RTCIS_IDX_ALM_DATE  4'h7
`define RTCIS_IDX_INTR      4'hC
`define RTCIS_IDX_FLAGS     4'hD

// ---------------------------------------------
// Interrupts register fields
// ---------------------------------------------
`define RTCIS_INTR_RATE_LSB 0
`define RTCIS_INTR_RATE_MSB 3
`define RTCIS_INTR_POWER_FAIL_IRQ_ENABLE    4
`define RTCIS_INTR_ABE      5
`define RTCIS_INTR_PIE      6
`define RTCIS_INTR_AIE      7
`define RTCIS_INTR_RESET    8'h00

// ---------------------------------------------
// Flags register fields
// ---------------------------------------------
`define RTCIS_FLG_BVF       0
`define RTCIS_FLG_POWER_FAIL_FLAG      1
`define RTCIS_FLG_PF        2
`define RTCIS_FLG_AF        3

// ---------------------------------------------
// Alarm byte layout
// ---------------------------------------------
`define RTCIS_ALM_MASK_HI   7
`define RTCIS_ALM_MASK_LO   6
`define RTCIS_ALM_RESET     8'h00

// ---------------------------------------------
// Timing
// ---------------------------------------------
`define RTCIS_CLK_PERIOD_NS 10
`define RTCIS_ADDR_HOLD_NS  50
`define RTCIS_WPT_NS        10000
`define RTCIS_PER_CNT_W     15

`endif

// file: src/rtcis_periodic.v
// Periodic event generator counting 32.768 kHz timebase ticks.
// Assumes tick_32k is a one-cycle pulse synchronous to clk.
`timescale 1ns/1ps
`include "rtcis_consts.vh"

module rtcis_periodic #(
    parameter CNT_W = `RTCIS_PER_CNT_W
) (
    input  wire       clk,
    input  wire       resetn,
    input  wire       ce,
    input  wire       tick_32k,
    input  wire [3:0] rate_sel,
    output reg        period_done
);

    reg [CNT_W-1:0] tick_count;
    reg [3:0]       last_rate;
    reg [CNT_W-1:0] next_limit;

    // ---------------------------------------------
    // Terminal count: code n gives 2^(n-1) ticks
    // ---------------------------------------------
    always @* begin
        next_limit = {CNT_W{1'b0}};
        if (rate_sel != 4'h0) begin
            next_limit = ({{(CNT_W-1){1'b0}}, 1'b1} << (rate_sel - 4'h1)) - 1'b1;
        end
    end

    always @(posedge clk) begin
        if (!resetn) begin
            tick_count  <= {CNT_W{1'b0}};
            last_rate   <= 4'h0;
            period_done <= 1'b0;
        end else if (ce) begin
            last_rate   <= rate_sel;
            period_done <= 1'b0;
            // Restart on a rate change so no stale interval fires
            if (rate_sel == 4'h0 || rate_sel != last_rate) begin
                tick_count <= {CNT_W{1'b0}};
            end else if (tick_32k) begin
                if (tick_count == next_limit) begin
                    tick_count  <= {CNT_W{1'b0}};
                    period_done <= 1'b1;
                end else begin
                    tick_count <= tick_count + 1'b1;
                end
            end
        end
    end

endmodule // rtcis_periodic

// file: sim/rtcis_props.sv
// Checker for the RTC interrupt-source block, bound to its top module.
// Assumes ce stays high while a bus request is open.
`timescale 1ns/1ps
`include "rtcis_consts.vh"

module rtcis_props #(
    parameter WPT_CYCLES  = 1000,
    parameter HOLD_CYCLES = 5
) (
    input wire        clk,
    input wire        resetn,
    input wire        ce,
    input wire [5:0]  address,
    input wire        read,
    input wire        write,
    input wire [31:0] writedata,
    input wire [3:0]  byteenable,
    input wire        waitrequest,
    input wire        tick_32k,
    input wire        update_strobe,
    input wire        power_fail_detect,
    input wire        backup_mode,
    input wire        irq_n_out,
    input wire        irq_n_oe_n,
    input wire        supervisor_reset_req
);
// ----------------------------
// Shadow of the enables
// ----------------------------
reg  [7:0]  intr;
reg  [15:0] fail_cnt;
wire        flags_acc = read && !waitrequest && address[5:2] == `RTCIS_IDX_FLAGS;

always @(posedge clk) begin
    if (!resetn)
        intr <= 8'h00;
    else if (ce && write && !waitrequest && byteenable[0] && address[5:2] == `RTCIS_IDX_INTR)
        intr <= writedata[7:0];
end

// Saturates so a long outage never wraps
always @(posedge clk) begin
    if (!resetn || !power_fail_detect)
        fail_cnt <= 16'h0000;
    else if (fail_cnt != 16'hFFFF)
        fail_cnt <= fail_cnt + 16'h0001;
end

// ----------------------------
// Properties
// ----------------------------
default clocking cb @(posedge clk); endclocking
default disable iff (!resetn);

a_irq_drive_low: assert property (!irq_n_oe_n |-> !irq_n_out)
    else $error("interrupt enabled while not driving low");
a_irq_needs_enable: assert property (!irq_n_oe_n && $stable(intr) |->
    intr[`RTCIS_INTR_POWER_FAIL_IRQ_ENABLE] || intr[`RTCIS_INTR_PIE] || intr[`RTCIS_INTR_AIE])
    else $error("interrupt driven with no enable set");
a_backup_quiet: assert property (backup_mode && $past(backup_mode) && $stable(intr)
    && !(intr[`RTCIS_INTR_ABE] && intr[`RTCIS_INTR_AIE]) |-> irq_n_oe_n)
    else $error("interrupt driven in backup mode");
a_wait_pulse: assert property (ce && !waitrequest |=> waitrequest)
    else $error("waitrequest low longer than one cycle");
// Five matches HOLD_CYCLES at its default
a_flags_hold: assert property ($rose(read) && address[5:2] == `RTCIS_IDX_FLAGS
    |-> waitrequest[*5] ##1 !waitrequest)
    else $error("flags read answered at wrong time");
a_write_answer: assert property ($rose(write) |-> waitrequest ##1 !waitrequest)
    else $error("write answered at wrong time");
a_read_release: assert property (flags_acc && !tick_32k && !$past(tick_32k)
    && !update_strobe && !power_fail_detect |-> ##2 irq_n_oe_n)
    else $error("interrupt not released after flags read");
a_fail_irq: assert property ($rose(power_fail_detect) && intr[`RTCIS_INTR_POWER_FAIL_IRQ_ENABLE]
    && !backup_mode |-> ##[1:3] !irq_n_oe_n)
    else $error("power-fail interrupt missing");
a_reset_delay: assert property ($rose(supervisor_reset_req) |->
    fail_cnt >= WPT_CYCLES && fail_cnt <= WPT_CYCLES + 1)
    else $error("reset request at wrong delay");
a_req_drop: assert property (!power_fail_detect |=> !supervisor_reset_req)
    else $error("reset request without power fail");

endmodule // rtcis_props

bind rtcis_top rtcis_props #(
    .WPT_CYCLES  (WPT_CYCLES),
    .HOLD_CYCLES (HOLD_CYCLES)
) u_rtcis_props (
    .clk, .resetn, .ce, .address, .read, .write, .writedata, .byteenable,
    .waitrequest, .tick_32k, .update_strobe, .power_fail_detect, .backup_mode,
    .irq_n_out, .irq_n_oe_n, .supervisor_reset_req
);

// file: sim/rtcis_host.sv
// Host processor model: Avalon-MM master for the interrupt-source block.
// Assumes the block answers every request; the bench watchdog ends a hang.
`timescale 1ns/1ps

module rtcis_host (
    input  wire        clk,
    input  wire        waitrequest,
    input  wire [31:0] readdata,
    output reg  [5:0]  address,
    output reg         read,
    output reg         write,
    output reg  [31:0] writedata,
    output reg  [3:0]  byteenable
);
// ----------------------------
// Bus transfer
// ----------------------------
initial begin
    address = 6'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'h0;
end

// Address held for the whole request so flags are never cleared by a glitch
task xfer(input rw, input [5:0] a, input [7:0] d, output [31:0] q);
    begin
        @(posedge clk);
        address <= a;
        read <= !rw;
        write <= rw;
        writedata <= {24'h00_0000, d};
        byteenable <= 4'h1;
        do
            @(posedge clk);
        while (waitrequest);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    end
endtask

endmodule // rtcis_host

// file: sim/tb.sv
// Testbench: periodic, alarm, backup, power-fail and battery flag paths.
// Assumes the host model owns every bus signal of the block.
`timescale 1ns/1ps
`include "rtcis_consts.vh"
`define CHK(nm, exp, got) begin \
    checks = checks + 1; \
    if ((got) !== (exp)) begin \
        n_fail = n_fail + 1; \
        $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
    end \
end

module tb;
// ----------------------------
// Signals
// ----------------------------
reg         clk;
reg         resetn;
reg         ce;
reg         tick_32k;
reg         update_strobe;
reg         power_fail_detect;
reg         backup_mode;
reg         battery_ok;
reg  [7:0]  now [0:3];
reg  [7:0]  c;
reg  [31:0] q;
wire [5:0]  address;
wire        read;
wire        write;
wire [31:0] writedata;
wire [3:0]  byteenable;
wire [31:0] readdata;
wire        waitrequest;
wire        irq_n_out;
wire        irq_n_oe_n;
wire        supervisor_reset_req;
wire        int_n = irq_n_oe_n ? 1'b1 : irq_n_out; // Board pull-up when released
integer     n_fail;
integer     checks;
integer     j;
integer     k;

rtcis_top #(.WPT_CYCLES(8)) u_rtcis_top (
    .clk(clk), .resetn(resetn), .ce(ce), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .tick_32k(tick_32k),
    .update_strobe(update_strobe), .cur_seconds(now[0]), .cur_minutes(now[1]),
    .cur_hours(now[2]), .cur_date(now[3]), .power_fail_detect(power_fail_detect),
    .backup_mode(backup_mode), .battery_ok(battery_ok), .irq_n_out(irq_n_out),
    .irq_n_oe_n(irq_n_oe_n), .supervisor_reset_req(supervisor_reset_req)
);

rtcis_host u_rtcis_host (
    .clk(clk), .waitrequest(waitrequest), .readdata(readdata), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable)
);

// ----------------------------
// Tasks
// ----------------------------
task wr(input [5:0] a, input [7:0] d);
    u_rtcis_host.xfer(1'b1, a, d, q);
endtask

task rd(input [5:0] a, input [7:0] exp);
    begin
        u_rtcis_host.xfer(1'b0, a, 8'h00, q);
        `CHK("readdata", {24'h00_0000, exp}, q)
    end
endtask

task tick;
    begin
        tick_32k <= 1'b1;
        @(posedge clk);
        tick_32k <= 1'b0;
        @(posedge clk);
    end
endtask

task strobe;
    begin
        update_strobe <= 1'b1;
        @(posedge clk);
        update_strobe <= 1'b0;
        @(posedge clk);
    end
endtask

task irq(input exp);
    begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        `CHK("int_n", exp, int_n)
        @(posedge clk);
    end
endtask

task summarize;
    begin
        if (n_fail == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
endtask

// ----------------------------
// Clock, watchdog, sequence
// ----------------------------
initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
end

// Longest code alone takes about 33k cycles
initial begin
    repeat (60000) @(posedge clk);
    n_fail = n_fail + 1;
    summarize;
end

initial begin
    n_fail = 0;
    checks = 0;
    resetn = 1'b0;
    ce = 1'b1;
    tick_32k = 1'b0;
    update_strobe = 1'b0;
    power_fail_detect = 1'b0;
    backup_mode = 1'b0;
    battery_ok = 1'b1;
    now[0] = 8'h59;
    now[1] = 8'h34;
    now[2] = 8'h12;
    now[3] = 8'h07;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rd(6'h30, 8'h00);
    rd(6'h34, 8'h01);
    rd(6'h08, 8'h00);
    wr(6'h30, 8'h40);
    repeat (4) tick;
    irq(1'b1);
    for (k = 1; k < 6; k = k + 1) begin
        c = (k == 5) ? 8'h0F : k[7:0];
        wr(6'h30, 8'h40 | c);
        // Divider restarts on the edge after a rate write; a tick there is lost
        @(posedge clk);
        repeat ((1 << (c - 1)) - 1) tick;
        irq(1'b1);
        tick;
        irq(1'b0);
        rd(6'h34, 8'h05);
        irq(1'b1);
        rd(6'h34, 8'h01);
    end
    wr(6'h30, 8'h80);
    for (j = 0; j < 4; j = j + 1)
        wr(6'(8 * j + 4), 8'hC0);
    strobe;
    irq(1'b0);
    rd(6'h34, 8'h09);
    for (k = 0; k < 4; k = k + 1) begin
        for (j = 0; j < 4; j = j + 1)
            wr(6'(8 * j + 4), j < k ? now[j] : j == k ? now[j] ^ 8'h40 : 8'hC0);
        strobe;
        irq(1'b1);
        wr(6'(8 * k + 4), now[k]);
        strobe;
        irq(1'b0);
        rd(6'h34, 8'h09);
    end
    for (j = 0; j < 4; j = j + 1)
        rd(6'(8 * j + 4), now[j]);
    wr(6'h30, 8'h40);
    strobe;
    irq(1'b1);
    rd(6'h34, 8'h09);
    backup_mode <= 1'b1;
    wr(6'h30, 8'h80);
    strobe;
    irq(1'b1);
    wr(6'h30, 8'hA0);
    u_rtcis_host.xfer(1'b0, 6'h34, 8'h00, q);
    strobe;
    irq(1'b0);
    u_rtcis_host.xfer(1'b0, 6'h34, 8'h00, q);
    backup_mode <= 1'b0;
    wr(6'h30, 8'h10);
    power_fail_detect <= 1'b1;
    irq(1'b0);
    `CHK("reset_req", 1'b0, supervisor_reset_req)
    repeat (8) @(posedge clk);
    @(negedge clk);
    `CHK("reset_req", 1'b1, supervisor_reset_req)
    @(posedge clk);
    power_fail_detect <= 1'b0;
    repeat (3) @(posedge clk);
    rd(6'h34, 8'h03);
    irq(1'b1);
    resetn <= 1'b0;
    battery_ok <= 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rd(6'h34, 8'h00);
    summarize;
end

endmodule // tb
